/* File: logic/dsa_top.sv */
// Purpose: debug pin framing with autobaud, plus the debug counter
// Assumes: debug pin input synchronous to clk; pin pulled high outside
// Notes: half duplex; receive is ignored while transmitting
`timescale 1ns/1ns
`include "dsa_cfg.svh"
module dsa_top import dsa_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // debug pin, open drain style
  input wire logic debug_pin_in,
  output logic debug_pin_out,
  output logic debug_pin_oe,
  // received characters
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_frame_err,
  // characters to send
  input wire logic [7:0] tx_data,
  input wire logic tx_start,
  output logic tx_busy,
  // link status
  output logic baud_locked,
  output logic [9:0] bit_period,
  // processor state and protection
  input wire logic debug_mode,
  input wire logic stop_mode,
  input wire logic read_protect_option,
  output logic full_cmd_enable,
  output logic stop_reset_req,
  // debug counter
  input dsa_cnt_mode_t cnt_mode,
  input wire logic cnt_load,
  input wire logic [15:0] cnt_load_value,
  input wire logic cnt_byte_dec,
  input wire logic [15:0] pc,
  input wire logic pc_valid,
  output logic [15:0] cnt_read,
  output logic cnt_break
);
  dsa_link_state_t lk_reg, lk_next;
  logic [`DSA_MEAS_W-1:0] meas_reg, meas_next;
  logic [`DSA_BIT_W-1:0] bit_reg, bit_next;
  logic [`DSA_BIT_W-1:0] rtim_reg, rtim_next;
  logic [3:0] rcnt_reg, rcnt_next;
  logic [7:0] rsh_reg, rsh_next;
  logic [7:0] rdat_reg, rdat_next;
  logic rval_reg, rval_next;
  logic rerr_reg, rerr_next;
  logic lock_reg, lock_next;
  logic [`DSA_BIT_W-1:0] half_bit;

  logic tbusy_reg, tbusy_next;
  logic [9:0] tsh_reg, tsh_next;
  logic [3:0] tcnt_reg, tcnt_next;
  logic [`DSA_BIT_W-1:0] ttim_reg, ttim_next;
  logic pout_reg, pout_next;
  logic poe_reg, poe_next;

  logic srst_reg, srst_next;
  logic full_reg, full_next;

  // half a bit for centre sampling, never below one cycle
  assign half_bit = (bit_reg >> 1) == `DSA_BIT_ZERO ? `DSA_BIT_ONE
                                                    : (bit_reg >> 1);

  // receive side and autobaud
  always_comb begin
    lk_next = lk_reg;
    meas_next = meas_reg;
    bit_next = bit_reg;
    rtim_next = rtim_reg;
    rcnt_next = rcnt_reg;
    rsh_next = rsh_reg;
    rdat_next = rdat_reg;
    rval_next = 1'b0;
    rerr_next = 1'b0;
    lock_next = lock_reg;
    case (lk_reg)
      LK_IDLE: begin
        // silent until the host's first falling edge
        if (!debug_pin_in) begin
          lk_next = LK_MEASURE;
          meas_next = `DSA_MEAS_ONE;
        end
      end
      LK_MEASURE: begin
        if (!debug_pin_in) begin
          // start bit plus seven low data bits of 80H
          meas_next = meas_reg + `DSA_MEAS_ONE;
          if (meas_reg == `DSA_MEAS_MAX) begin
            lk_next = LK_IDLE;
          end
        end else if ((meas_reg >> `DSA_DIV_SHIFT) == `DSA_MEAS_W'(0)) begin
          lk_next = LK_IDLE;
        end else begin
          bit_next = `DSA_BIT_W'(meas_reg >> `DSA_DIV_SHIFT);
          lock_next = 1'b1;
          lk_next = LK_READY;
        end
      end
      LK_READY: begin
        if (!debug_pin_in && !tbusy_reg) begin
          rtim_next = half_bit;
          lk_next = LK_START;
        end
      end
      LK_START: begin
        rtim_next = rtim_reg - `DSA_BIT_ONE;
        if (rtim_reg == `DSA_BIT_ONE) begin
          if (!debug_pin_in) begin
            rtim_next = bit_reg;
            rcnt_next = 4'h0;
            lk_next = LK_DATA;
          end else begin
            lk_next = LK_READY;
          end
        end
      end
      LK_DATA: begin
        rtim_next = rtim_reg - `DSA_BIT_ONE;
        if (rtim_reg == `DSA_BIT_ONE) begin
          rtim_next = bit_reg;
          rsh_next = {debug_pin_in, rsh_reg[7:1]};
          rcnt_next = rcnt_reg + 4'h1;
          if (rcnt_reg == `DSA_DATA_BITS - 4'h1) begin
            lk_next = LK_STOP;
          end
        end
      end
      LK_STOP: begin
        rtim_next = rtim_reg - `DSA_BIT_ONE;
        if (rtim_reg == `DSA_BIT_ONE) begin
          rdat_next = rsh_reg;
          rval_next = debug_pin_in;
          rerr_next = !debug_pin_in;
          lk_next = LK_READY;
        end
      end
      default: begin
        lk_next = LK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lk_reg <= LK_IDLE;
      meas_reg <= `DSA_MEAS_W'(0);
      bit_reg <= `DSA_BIT_ZERO;
      rtim_reg <= `DSA_BIT_ZERO;
      rcnt_reg <= 4'h0;
      rsh_reg <= 8'h00;
      rdat_reg <= 8'h00;
      rval_reg <= 1'b0;
      rerr_reg <= 1'b0;
      lock_reg <= 1'b0;
    end else begin
      lk_reg <= lk_next;
      meas_reg <= meas_next;
      bit_reg <= bit_next;
      rtim_reg <= rtim_next;
      rcnt_reg <= rcnt_next;
      rsh_reg <= rsh_next;
      rdat_reg <= rdat_next;
      rval_reg <= rval_next;
      rerr_reg <= rerr_next;
      lock_reg <= lock_next;
    end
  end

  // transmit side, same bit time as receive
  always_comb begin
    tbusy_next = tbusy_reg;
    tsh_next = tsh_reg;
    tcnt_next = tcnt_reg;
    ttim_next = ttim_reg;
    pout_next = pout_reg;
    poe_next = poe_reg;
    if (!tbusy_reg) begin
      // a start while receiving is dropped; caller watches tx_busy
      if (tx_start && lk_reg == LK_READY && debug_pin_in) begin
        tbusy_next = 1'b1;
        tsh_next = {1'b1, tx_data, 1'b0};
        tcnt_next = `DSA_CHAR_BITS;
        ttim_next = bit_reg;
        pout_next = 1'b0;
        poe_next = 1'b1;
      end
    end else begin
      ttim_next = ttim_reg - `DSA_BIT_ONE;
      if (ttim_reg == `DSA_BIT_ONE) begin
        ttim_next = bit_reg;
        tsh_next = {1'b1, tsh_reg[9:1]};
        tcnt_next = tcnt_reg - 4'h1;
        pout_next = tsh_reg[1];
        if (tcnt_reg == 4'h1) begin
          tbusy_next = 1'b0;
          pout_next = 1'b1;
          poe_next = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tbusy_reg <= 1'b0;
      tsh_reg <= 10'h3FF;
      tcnt_reg <= 4'h0;
      ttim_reg <= `DSA_BIT_ZERO;
      pout_reg <= 1'b1;
      poe_reg <= 1'b0;
    end else begin
      tbusy_reg <= tbusy_next;
      tsh_reg <= tsh_next;
      tcnt_reg <= tcnt_next;
      ttim_reg <= ttim_next;
      pout_reg <= pout_next;
      poe_reg <= poe_next;
    end
  end

  // stop-mode wake reset and command gating
  always_comb begin
    srst_next = stop_mode && !debug_pin_in;
    full_next = debug_mode && !read_protect_option;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      srst_reg <= 1'b0;
      full_reg <= 1'b0;
    end else begin
      srst_reg <= srst_next;
      full_reg <= full_next;
    end
  end

  dsa_counter u_counter (
    .clk(clk),
    .rst(rst),
    .cnt_mode(cnt_mode),
    .debug_mode(debug_mode),
    .cnt_load(cnt_load),
    .cnt_load_value(cnt_load_value),
    .cnt_byte_dec(cnt_byte_dec),
    .pc(pc),
    .pc_valid(pc_valid),
    .cnt_read(cnt_read),
    .cnt_break(cnt_break)
  );

  assign debug_pin_out = pout_reg;
  assign debug_pin_oe = poe_reg;
  assign rx_data = rdat_reg;
  assign rx_valid = rval_reg;
  assign rx_frame_err = rerr_reg;
  assign tx_busy = tbusy_reg;
  assign baud_locked = lock_reg;
  assign bit_period = bit_reg;
  assign full_cmd_enable = full_reg;
  assign stop_reset_req = srst_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_idle_silent: assert property (!baud_locked |-> !debug_pin_oe)
    else $error("pin driven before baud lock");
  chk_lock_period: assert property (
    $rose(baud_locked) |-> bit_period == $past(meas_reg) >> `DSA_DIV_SHIFT)
    else $error("bit period not low period over eight");
  chk_div_range: assert property (
    baud_locked |-> bit_period != `DSA_BIT_ZERO
      && bit_period <= `DSA_BIT_MAX)
    else $error("bit period out of range");
  chk_start_bit: assert property (
    $rose(debug_pin_oe) |-> !debug_pin_out ##1 !debug_pin_out || tx_busy)
    else $error("transmit did not open with a low start bit");
  chk_stop_reset: assert property (
    stop_mode && !debug_pin_in |=> stop_reset_req)
    else $error("low pin in stop mode gave no reset request");
  chk_cmd_gate: assert property (
    read_protect_option |=> !full_cmd_enable)
    else $error("full commands enabled under read protection");
endmodule : dsa_top

/* File: logic/dsa_cfg.svh */
// Purpose: constants for the debug serial port and debug counter
// Assumes: 125 MHz system clock, pin data synchronous to it
// Notes: period and length limits below are in system clock cycles; DSA_DATA_BITS and DSA_CHAR_BITS are in bits
`ifndef DSA_CFG_SVH
`define DSA_CFG_SVH
`define DSA_DATA_BITS 4'h8
`define DSA_MEAS_W 13
`define DSA_BIT_W 10
`define DSA_MEAS_MAX 13'h1000
`define DSA_MEAS_ONE 13'h0001
`define DSA_DIV_SHIFT 3
`define DSA_BIT_MAX 10'h200
`define DSA_BIT_ZERO 10'h000
`define DSA_BIT_ONE 10'h001
`define DSA_CNT_MAX 16'hFFFF
`define DSA_CNT_ZERO 16'h0000
`define DSA_CNT_ONE 16'h0001
`define DSA_CHAR_BITS 4'hA
`endif

/* File: logic/dsa_pkg.sv */
// Purpose: types shared by the debug serial port and its counter
// Assumes: nothing beyond the cfg header
// Notes: enums carry no explicit codes
package dsa_pkg;
  typedef enum logic [1:0] {
    DSA_CNT_CYCLE,
    DSA_CNT_DOWN,
    DSA_CNT_MATCH
  } dsa_cnt_mode_t;
  typedef enum logic [2:0] {
    LK_IDLE,
    LK_MEASURE,
    LK_READY,
    LK_START,
    LK_DATA,
    LK_STOP
  } dsa_link_state_t;
endpackage : dsa_pkg

/* File: logic/dsa_counter.sv */
// Purpose: 16-bit debug counter with cycle, count-down and match uses
// Assumes: debug_mode high while the processor is halted
// Notes: stored value is read back inverted
`timescale 1ns/1ns
`include "dsa_cfg.svh"
module dsa_counter import dsa_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input dsa_cnt_mode_t cnt_mode,
  input wire logic debug_mode,
  input wire logic cnt_load,
  input wire logic [15:0] cnt_load_value,
  input wire logic cnt_byte_dec,
  // program counter
  input wire logic [15:0] pc,
  input wire logic pc_valid,
  // results
  output logic [15:0] cnt_read,
  output logic cnt_break
);
  logic [15:0] value_reg, value_next;
  logic [15:0] read_reg, read_next;
  logic brk_reg, brk_next;
  logic dbg_reg, dbg_next;
  logic leaving;

  always_comb begin
    value_next = value_reg;
    brk_next = 1'b0;
    dbg_next = debug_mode;
    leaving = dbg_reg && !debug_mode;
    if (cnt_load) begin
      value_next = cnt_load_value;
    end else if (debug_mode) begin
      // command byte counting; residue kept afterwards except in cycle mode, which loads DSA_CNT_MAX on leaving
      if (cnt_byte_dec && value_reg != `DSA_CNT_ZERO) begin
        value_next = value_reg - `DSA_CNT_ONE;
      end
    end else begin
      case (cnt_mode)
        DSA_CNT_CYCLE: begin
          if (leaving) begin
            value_next = `DSA_CNT_MAX;
          end else if (value_reg != `DSA_CNT_ZERO) begin
            value_next = value_reg - `DSA_CNT_ONE;
          end
        end
        DSA_CNT_DOWN: begin
          if (value_reg != `DSA_CNT_ZERO) begin
            value_next = value_reg - `DSA_CNT_ONE;
            brk_next = (value_reg == `DSA_CNT_ONE);
          end
        end
        DSA_CNT_MATCH: begin
          brk_next = pc_valid && (pc == value_reg);
        end
        default: begin
          value_next = value_reg;
        end
      endcase
    end
    read_next = ~value_next;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_reg <= `DSA_CNT_ZERO;
      read_reg <= `DSA_CNT_MAX;
      brk_reg <= 1'b0;
      dbg_reg <= 1'b0;
    end else begin
      value_reg <= value_next;
      read_reg <= read_next;
      brk_reg <= brk_next;
      dbg_reg <= dbg_next;
    end
  end

  assign cnt_read = read_reg;
  assign cnt_break = brk_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_read_inverse: assert property (cnt_read == ~value_reg)
    else $error("counter read is not the inverse of the stored value");
  chk_load_read: assert property (
    cnt_load |=> cnt_read == ~$past(cnt_load_value))
    else $error("loaded value not read back inverted");
  chk_never_up: assert property (
    (value_next > value_reg) |-> (cnt_load || leaving))
    else $error("counter moved upward without load or clear");
  chk_cycle_clear: assert property (
    (cnt_mode == DSA_CNT_CYCLE && leaving && !cnt_load)
      |=> value_reg == `DSA_CNT_MAX)
    else $error("cycle counter not cleared on leaving debug");
  chk_debug_freeze: assert property (
    (debug_mode && !cnt_load && !cnt_byte_dec) |=> $stable(value_reg))
    else $error("counter moved while halted");
  chk_match_break: assert property (
    (cnt_mode == DSA_CNT_MATCH && !debug_mode && !cnt_load && pc_valid
      && pc == value_reg) |=> cnt_break)
    else $error("address match gave no break");
  chk_down_break: assert property (
    (cnt_mode == DSA_CNT_DOWN && !debug_mode && !cnt_load
      && value_reg == `DSA_CNT_ONE)
      |=> cnt_break && value_reg == `DSA_CNT_ZERO)
    else $error("count-down did not break at zero");
endmodule : dsa_counter

/* File: tb/dsa_host.sv */
// Purpose: debug host model on the open-drain debug pin
// Assumes: pin pulled high whenever nobody pulls it low
// Notes: bit time of the decoder is set by the bench in rx_p
`timescale 1ns/1ns
module dsa_host (
  // clock
  input wire logic clk,
  // debug pin
  input wire logic pin,
  output logic host_low,
  // characters decoded from the device
  output logic [7:0] got_byte,
  output logic got_valid
);
  int rx_p = 16;
  initial begin
    host_low = 1'b0;
    got_byte = 8'h00;
    got_valid = 1'b0;
  end
  // start, data lsb first, stop; bit time never under 8 clocks
  task automatic send(input logic [7:0] b, input int p);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_low <= ~fr[i];
      repeat (p) @(posedge clk);
    end
  endtask : send
  task automatic pull_low(input int n);
    host_low <= 1'b1;
    repeat (n) @(posedge clk);
    host_low <= 1'b0;
  endtask : pull_low
  // mid-bit sampling; a bad stop bit drops the byte
  initial begin
    forever begin
      @(posedge clk);
      if (pin === 1'b0 && !host_low) begin
        repeat (rx_p / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
          repeat (rx_p) @(posedge clk);
          got_byte[i] <= pin;
        end
        repeat (rx_p) @(posedge clk);
        got_valid <= (pin === 1'b1);
        @(posedge clk);
        got_valid <= 1'b0;
      end
    end
  end
endmodule : dsa_host

/* File: tb/tb.sv */
// Purpose: self-checking bench for the debug serial port and counter
// Assumes: open-drain pin with pull-up, modelled by the wire equation
// Notes: first link phase runs at the slowest bit time, after reset
`timescale 1ns/1ns
module tb import dsa_pkg::*;;
  logic clk, rst, pin, host_low, got_valid;
  logic [7:0] got_byte, rx_data, tx_data;
  logic debug_pin_out, debug_pin_oe, rx_valid, rx_frame_err;
  logic tx_start, tx_busy, baud_locked, debug_mode, stop_mode;
  logic read_protect_option, full_cmd_enable, stop_reset_req;
  logic cnt_load, cnt_byte_dec, pc_valid, cnt_break;
  logic [9:0] bit_period;
  logic [15:0] cnt_load_value, pc, cnt_read, r1, r2;
  dsa_cnt_mode_t cnt_mode;
  logic [7:0] rxq[$];
  logic [7:0] txq[$];
  int n_fail = 0;
  int compares = 0;
  int brk_cnt = 0;
  int n_ferr = 0;
  int seed = 5;
  int k, b0;
  assign pin = ~(host_low | (debug_pin_oe & ~debug_pin_out));
  dsa_top dsa_top_i (.clk(clk), .rst(rst), .debug_pin_in(pin),
    .debug_pin_out(debug_pin_out), .debug_pin_oe(debug_pin_oe),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_frame_err(rx_frame_err),
    .tx_data(tx_data), .tx_start(tx_start), .tx_busy(tx_busy),
    .baud_locked(baud_locked), .bit_period(bit_period),
    .debug_mode(debug_mode), .stop_mode(stop_mode),
    .read_protect_option(read_protect_option),
    .full_cmd_enable(full_cmd_enable), .stop_reset_req(stop_reset_req),
    .cnt_mode(cnt_mode), .cnt_load(cnt_load),
    .cnt_load_value(cnt_load_value), .cnt_byte_dec(cnt_byte_dec),
    .pc(pc), .pc_valid(pc_valid), .cnt_read(cnt_read),
    .cnt_break(cnt_break));
  dsa_host dsa_host_i (.clk(clk), .pin(pin), .host_low(host_low),
    .got_byte(got_byte), .got_valid(got_valid));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic do_reset();
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset
  task automatic load(input logic [15:0] v);
    cnt_load <= 1'b1;
    cnt_load_value <= v;
    @(posedge clk);
    cnt_load <= 1'b0;
  endtask : load
  task automatic link_phase(input int p);
    logic [7:0] b;
    dsa_host_i.rx_p = p;
    repeat (40) @(posedge clk);
    check({15'h0000, debug_pin_oe}, 16'h0000);
    dsa_host_i.pull_low(5);
    repeat (20) @(posedge clk);
    check({15'h0000, baud_locked}, 16'h0000);
    dsa_host_i.send(8'h80, p);
    check({6'h00, bit_period}, 16'(p));
    for (int i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      rxq.push_back(b);
      dsa_host_i.send(b, p);
    end
    // a held-low line fails the stop bit and delivers nothing
    k = n_ferr;
    dsa_host_i.pull_low(10 * p);
    repeat (p) @(posedge clk);
    check(16'(n_ferr - k), 16'h0001);
    repeat (p) @(posedge clk);
    // back to back: next request right after busy falls
    for (int i = 0; i < 2; i++) begin
      b = 8'($random(seed));
      txq.push_back(b);
      tx_data <= b;
      tx_start <= 1'b1;
      @(posedge clk);
      tx_start <= 1'b0;
      @(posedge clk);
      k = 0;
      while (tx_busy === 1'b1 && k < 12 * p) begin
        @(posedge clk);
        k++;
      end
      check(16'(k), 16'(10 * p));
      if (k >= 12 * p) test_done();
    end
  endtask : link_phase
  // outputs watched against the oldest expectation
  always @(posedge clk) begin
    if (cnt_break === 1'b1) brk_cnt++;
    if (rx_frame_err === 1'b1) n_ferr++;
    if (rx_valid === 1'b1) begin
      if (rxq.size() == 0) check({8'h01, rx_data}, 16'h0000);
      else check({8'h00, rx_data}, {8'h00, rxq.pop_front()});
    end
    if (got_valid === 1'b1) begin
      if (txq.size() == 0) check({8'h01, got_byte}, 16'h0000);
      else check({8'h00, got_byte}, {8'h00, txq.pop_front()});
    end
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    tx_data = 8'h00;
    tx_start = 1'b0;
    debug_mode = 1'b1;
    stop_mode = 1'b0;
    read_protect_option = 1'b0;
    cnt_mode = DSA_CNT_DOWN;
    cnt_load = 1'b0;
    cnt_load_value = 16'h0000;
    cnt_byte_dec = 1'b0;
    pc = 16'h0000;
    pc_valid = 1'b0;
    do_reset();
    link_phase(512);
    do_reset();
    link_phase(16);
    load(16'hA5C3);
    cnt_byte_dec <= 1'b1;
    repeat (3) @(posedge clk);
    cnt_byte_dec <= 1'b0;
    @(negedge clk);
    check(cnt_read, 16'h5A3F);
    @(posedge clk);
    load(16'h0003);
    b0 = brk_cnt;
    debug_mode <= 1'b0;
    repeat (8) @(posedge clk);
    check(16'(brk_cnt - b0), 16'h0001);
    check(cnt_read, 16'hFFFF);
    debug_mode <= 1'b1;
    load(16'h0040);
    debug_mode <= 1'b0;
    repeat (4) @(posedge clk);
    debug_mode <= 1'b1;
    repeat (3) @(negedge clk);
    r1 = cnt_read;
    repeat (10) @(negedge clk);
    check(cnt_read, r1);
    check({15'h0000, r1 > 16'hFFBF && r1 < 16'hFFC6}, 16'h0001);
    @(posedge clk);
    cnt_mode <= DSA_CNT_CYCLE;
    load(16'h1234);
    debug_mode <= 1'b0;
    repeat (4) @(negedge clk);
    r1 = cnt_read;
    @(negedge clk);
    r2 = cnt_read;
    check(r2, r1 + 16'h0001);
    check({15'h0000, r1 < 16'h0010}, 16'h0001);
    @(posedge clk);
    load(16'h0002);
    repeat (8) @(posedge clk);
    check(cnt_read, 16'hFFFF);
    debug_mode <= 1'b1;
    cnt_mode <= DSA_CNT_MATCH;
    load(16'h0400);
    b0 = brk_cnt;
    debug_mode <= 1'b0;
    pc_valid <= 1'b1;
    for (int a = 16'h03FC; a < 16'h0403; a++) begin
      pc <= 16'(a);
      @(posedge clk);
    end
    pc_valid <= 1'b0;
    repeat (3) @(negedge clk);
    check(16'(brk_cnt - b0), 16'h0001);
    check(cnt_read, 16'hFBFF);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      debug_mode <= i[1];
      read_protect_option <= i[0];
      repeat (2) @(negedge clk);
      check({15'h0000, full_cmd_enable}, {15'h0000, i[1] & ~i[0]});
    end
    @(posedge clk);
    stop_mode <= 1'b1;
    repeat (2) @(negedge clk);
    check({15'h0000, stop_reset_req}, 16'h0000);
    @(posedge clk);
    dsa_host_i.pull_low(4);
    @(negedge clk);
    check({15'h0000, stop_reset_req}, 16'h0001);
    repeat (2) @(negedge clk);
    check({15'h0000, stop_reset_req}, 16'h0000);
    k = 0;
    while ((rxq.size() != 0 || txq.size() != 0) && k < 2000) begin
      @(posedge clk);
      k++;
    end
    check(16'(rxq.size() + txq.size()), 16'h0000);
    test_done();
  end
endmodule : tb
